//--- hw/pin_change_flags.v
// Pin change edge flags with AXI4-Lite register access and a level interrupt.
// Assumes one clock; pins are asynchronous and arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_defs.vh"
module pin_change_flags (
  input wire clock_i,
  input wire rst_b_i,
  input wire [7:0] port_a_pin_i,
  input wire [7:0] port_b_pin_i,
  input wire [7:0] port_c_pin_i,
  input wire port_e_bit3_pin_i,
  input wire external_reset_pin_enable_i,
  input wire low_voltage_programming_enable_i,
  input wire [`BYTE_ADDR_BITS-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`BYTE_ADDR_BITS-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg pin_change_summary_flag_o,
  output wire pin_change_request_o,
  output wire wake_request_o,
  output wire irq_o
);
  reg rst_meta;
  reg rst_b;
  // Reset asserts at once and releases two edges later, so all flops leave it together.
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b <= rst_meta;
    end
  end

  reg [7:0] port_a_change_flags;
  reg [7:0] port_a_fall_enable;
  reg [7:0] port_a_rise_enable;
  reg [7:0] port_b_change_flags;
  reg [7:0] port_b_fall_enable;
  reg [7:0] port_b_rise_enable;
  reg [7:0] port_c_change_flags;
  reg [7:0] port_c_fall_enable;
  reg [7:0] port_c_rise_enable;
  // Port E keeps only bit 3 of its flag and enable registers.
  reg port_e_change_flag;
  reg port_e_fall_enable;
  reg port_e_rise_enable;
  reg pin_change_global_enable;
  reg irq_status;
  reg irq_mask;

  // Index of a printed offset: the byte address is four times the offset.
  function [11:0] reg_index;
    input [`BYTE_ADDR_BITS-1:0] byte_addr;
    begin
      reg_index = byte_addr[`BYTE_ADDR_BITS-1:2];
    end
  endfunction

  // One-cycle edge pulses from the detectors, one bit per pin.
  wire [7:0] rise_a;
  wire [7:0] fall_a;
  wire [7:0] rise_b;
  wire [7:0] fall_b;
  wire [7:0] rise_c;
  wire [7:0] fall_c;
  wire [0:0] rise_e;
  wire [0:0] fall_e;

  // Each port has its own detector; port E watches only its bit 3 pin.
  edge_detect #(.WIDTH(8)) detect_a (
    .clock_i(clock_i),
    .rst_b_i(rst_b),
    .pin_i(port_a_pin_i),
    .rise_o(rise_a),
    .fall_o(fall_a)
  );
  edge_detect #(.WIDTH(8)) detect_b (
    .clock_i(clock_i),
    .rst_b_i(rst_b),
    .pin_i(port_b_pin_i),
    .rise_o(rise_b),
    .fall_o(fall_b)
  );
  edge_detect #(.WIDTH(8)) detect_c (
    .clock_i(clock_i),
    .rst_b_i(rst_b),
    .pin_i(port_c_pin_i),
    .rise_o(rise_c),
    .fall_o(fall_c)
  );
  edge_detect #(.WIDTH(1)) detect_e (
    .clock_i(clock_i),
    .rst_b_i(rst_b),
    .pin_i(port_e_bit3_pin_i),
    .rise_o(rise_e),
    .fall_o(fall_e)
  );

  // port E bit 3 removed when either configuration is set
  wire port_e_available = ~(external_reset_pin_enable_i | low_voltage_programming_enable_i);

  wire [7:0] hit_b = (rise_b & port_b_rise_enable) | (fall_b & port_b_fall_enable);
  wire [7:0] hit_c = (rise_c & port_c_rise_enable) | (fall_c & port_c_fall_enable);
  // falling enables and rising enables arm port A
  wire [7:0] hit_a = (rise_a & port_a_rise_enable) | (fall_a & port_a_fall_enable);
  wire hit_e = port_e_available &
               ((rise_e[0] & port_e_rise_enable) | (fall_e[0] & port_e_fall_enable));
  // Any armed edge on any port also sets the sticky event status.
  wire any_hit = (|hit_a) | (|hit_b) | (|hit_c) | hit_e;

  // Write channel: address and data taken together once both are offered.
  // A new write waits while its response stands, so one write at most is under way.
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  wire [11:0] wr_idx = reg_index(s_axi_awaddr);
  wire wr_lane = wr_go & s_axi_wstrb[0];
  // Only byte lane 0 carries register data; the upper lanes are ignored.
  wire [7:0] wd = s_axi_wdata[7:0];

  // Unmapped offsets answer with a slave error so that software sees the bad address.
  function is_mapped;
    input [11:0] idx;
    begin
      case (idx)
        `OFS_PORT_A_CHANGE_FLAGS, `OFS_PORT_A_FALL_ENABLE, `OFS_PORT_A_RISE_ENABLE,
        `OFS_PORT_B_CHANGE_FLAGS, `OFS_PORT_B_FALL_ENABLE, `OFS_PORT_B_RISE_ENABLE,
        `OFS_PORT_C_CHANGE_FLAGS, `OFS_PORT_C_FALL_ENABLE, `OFS_PORT_C_RISE_ENABLE,
        `OFS_PORT_E_CHANGE_FLAGS, `OFS_PORT_E_FALL_ENABLE, `OFS_PORT_E_RISE_ENABLE,
        `OFS_CONTROL, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // software write keeps only bits written as one; new edges win
  function [7:0] next_flags;
    input [7:0] cur;
    input wr;
    input [7:0] data;
    input [7:0] hit;
    begin
      next_flags = (wr ? (cur & data) : cur) | hit;
    end
  endfunction

  // Each flag write touches only the flag register that its address selects.
  wire wr_a_f = wr_lane & (wr_idx == `OFS_PORT_A_CHANGE_FLAGS);
  wire wr_b_f = wr_lane & (wr_idx == `OFS_PORT_B_CHANGE_FLAGS);
  wire wr_c_f = wr_lane & (wr_idx == `OFS_PORT_C_CHANGE_FLAGS);
  wire wr_e_f = wr_lane & (wr_idx == `OFS_PORT_E_CHANGE_FLAGS);

  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      port_a_change_flags <= `REG_RESET;
      port_a_fall_enable <= `REG_RESET;
      port_a_rise_enable <= `REG_RESET;
      port_b_change_flags <= `REG_RESET;
      port_b_fall_enable <= `REG_RESET;
      port_b_rise_enable <= `REG_RESET;
      port_c_change_flags <= `REG_RESET;
      port_c_fall_enable <= `REG_RESET;
      port_c_rise_enable <= `REG_RESET;
      port_e_change_flag <= 1'b0;
      port_e_fall_enable <= 1'b0;
      port_e_rise_enable <= 1'b0;
      pin_change_global_enable <= 1'b0;
      irq_mask <= 1'b0;
    end else begin
      // Software cannot set a flag: a written one only keeps a flag that is set.
      // pin flags set on armed edges; regardless of global enable
      port_a_change_flags <= next_flags(port_a_change_flags, wr_a_f, wd, hit_a);
      port_b_change_flags <= next_flags(port_b_change_flags, wr_b_f, wd, hit_b);
      port_c_change_flags <= next_flags(port_c_change_flags, wr_c_f, wd, hit_c);
      // edge wins over a clearing write
      port_e_change_flag <= (wr_e_f ? (port_e_change_flag & wd[`PORT_E_BIT]) :
                             port_e_change_flag) | hit_e;
      // Enable and control writes take effect on the edge that accepts the write.
      if (wr_lane) begin
        case (wr_idx)
          `OFS_PORT_A_FALL_ENABLE: port_a_fall_enable <= wd;
          `OFS_PORT_B_FALL_ENABLE: port_b_fall_enable <= wd;
          `OFS_PORT_C_FALL_ENABLE: port_c_fall_enable <= wd;
          `OFS_PORT_E_FALL_ENABLE: port_e_fall_enable <= wd[`PORT_E_BIT];
          `OFS_PORT_A_RISE_ENABLE: port_a_rise_enable <= wd;
          `OFS_PORT_B_RISE_ENABLE: port_b_rise_enable <= wd;
          `OFS_PORT_C_RISE_ENABLE: port_c_rise_enable <= wd;
          `OFS_PORT_E_RISE_ENABLE: port_e_rise_enable <= wd[`PORT_E_BIT];
          `OFS_CONTROL: pin_change_global_enable <= wd[`CTRL_GLOBAL_ENABLE_BIT];
          `OFS_IRQ_MASK: irq_mask <= wd[`IRQ_SUMMARY_BIT];
          default: ;
        endcase
      end
    end
  end

  // summary is the OR of all per-pin flags
  // The registered summary lags the flags by one edge.
  wire next_summary = (|port_a_change_flags) | (|port_b_change_flags) |
                      (|port_c_change_flags) | port_e_change_flag;
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      pin_change_summary_flag_o <= 1'b0;
    end else begin
      pin_change_summary_flag_o <= next_summary;
    end
  end

  // only the request, and the wake taken from it, is gated by the global enable
  assign pin_change_request_o = pin_change_summary_flag_o & pin_change_global_enable;
  // wake once flags are already stored
  assign wake_request_o = pin_change_request_o;

  // Sticky event status: set by any armed edge, cleared by writing one; set wins.
  wire irq_clr = wr_lane & (wr_idx == `OFS_IRQ_STATUS) & wd[`IRQ_SUMMARY_BIT];
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= 1'b0;
    end else begin
      irq_status <= any_hit | (irq_status & ~irq_clr);
    end
  end
  // The interrupt output is a level, high while the unmasked status bit is set.
  assign irq_o = irq_status & irq_mask;

  // The response follows the write by one edge and stands until bready is seen.
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_idx) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data.
  // A new read waits while its data stands, so one read at most is under way.
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;
  wire [11:0] rd_idx = reg_index(s_axi_araddr);
  reg [7:0] rd_byte;
  // The read multiplexer is combinational; only its registered copy leaves the block.
  always @* begin
    case (rd_idx)
      `OFS_PORT_A_CHANGE_FLAGS: rd_byte = port_a_change_flags;
      `OFS_PORT_A_FALL_ENABLE: rd_byte = port_a_fall_enable;
      `OFS_PORT_A_RISE_ENABLE: rd_byte = port_a_rise_enable;
      `OFS_PORT_B_CHANGE_FLAGS: rd_byte = port_b_change_flags;
      `OFS_PORT_B_FALL_ENABLE: rd_byte = port_b_fall_enable;
      `OFS_PORT_B_RISE_ENABLE: rd_byte = port_b_rise_enable;
      `OFS_PORT_C_CHANGE_FLAGS: rd_byte = port_c_change_flags;
      `OFS_PORT_C_FALL_ENABLE: rd_byte = port_c_fall_enable;
      `OFS_PORT_C_RISE_ENABLE: rd_byte = port_c_rise_enable;
      // unimplemented port E bits read zero
      `OFS_PORT_E_CHANGE_FLAGS: rd_byte = {4'h0, port_e_change_flag, 3'h0};
      `OFS_PORT_E_FALL_ENABLE: rd_byte = {4'h0, port_e_fall_enable, 3'h0};
      `OFS_PORT_E_RISE_ENABLE: rd_byte = {4'h0, port_e_rise_enable, 3'h0};
      `OFS_CONTROL: rd_byte = {7'h00, pin_change_global_enable};
      `OFS_IRQ_STATUS: rd_byte = {7'h00, irq_status};
      `OFS_IRQ_MASK: rd_byte = {7'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is registered, so it stands unchanged until rready is seen.
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= is_mapped(rd_idx) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pin_change_flags
`default_nettype wire

//--- hw/pin_change_defs.vh
// Register offsets, field positions and reset values for the pin change block.
// Included by the design files; holds definitions only.
`ifndef PIN_CHANGE_DEFS_VH
`define PIN_CHANGE_DEFS_VH

`define OFS_PORT_A_CHANGE_FLAGS 12'hf0a
`define OFS_PORT_A_FALL_ENABLE 12'hf0b
`define OFS_PORT_A_RISE_ENABLE 12'hf0c
`define OFS_PORT_B_CHANGE_FLAGS 12'hf12
`define OFS_PORT_B_FALL_ENABLE 12'hf13
`define OFS_PORT_B_RISE_ENABLE 12'hf14
`define OFS_PORT_C_CHANGE_FLAGS 12'hf1a
`define OFS_PORT_C_FALL_ENABLE 12'hf1b
`define OFS_PORT_C_RISE_ENABLE 12'hf1c
`define OFS_PORT_E_CHANGE_FLAGS 12'hf27
`define OFS_PORT_E_FALL_ENABLE 12'hf28
`define OFS_PORT_E_RISE_ENABLE 12'hf29
`define OFS_CONTROL 12'hf40
`define OFS_IRQ_STATUS 12'hf41
`define OFS_IRQ_MASK 12'hf42

`define PORT_E_BIT 3
`define PORT_E_MASK 8'h08
`define CTRL_GLOBAL_ENABLE_BIT 0
`define IRQ_SUMMARY_BIT 0
`define REG_RESET 8'h00
`define BYTE_ADDR_BITS 14

`endif

//--- hw/edge_detect.v
// Pin synchroniser and edge detector for a group of port pins.
// Assumes pins are asynchronous to clock_i; reset is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module edge_detect #(
  parameter WIDTH = 8
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);
  reg [WIDTH-1:0] sync_1;
  reg [WIDTH-1:0] sync_2;
  reg [WIDTH-1:0] sync_3;
  reg [WIDTH-1:0] level;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_1 <= {WIDTH{1'b0}};
      sync_2 <= {WIDTH{1'b0}};
      sync_3 <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      sync_1 <= pin_i;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      // A change counts once the second and third stages agree.
      level <= ((sync_2 == sync_3) ? sync_3 : level);
    end
  end

  wire [WIDTH-1:0] agreed = (sync_2 == sync_3) ? sync_3 : level;
  assign rise_o = agreed & ~level;
  assign fall_o = ~agreed & level;
endmodule // edge_detect
`default_nettype wire

//--- verification/pin_change_flags_sva.sv
// Checker for the register bus handshakes and the request outputs.
// Sees only top-level ports; it is bound below.
`timescale 1ns/1ps
`default_nettype none
module pin_change_flags_sva (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic pin_change_summary_flag_o,
  input wire logic pin_change_request_o,
  input wire logic wake_request_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_addr_data_pair: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
    else $error("write channels not taken together");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_bresp_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid ##0 s_axi_rdata[31:8] == 24'h0)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_request_gate: assert property (pin_change_request_o |-> pin_change_summary_flag_o)
    else $error("request without summary flag");
  a_wake_match: assert property (wake_request_o == pin_change_request_o)
    else $error("wake request differs from request");
endmodule // pin_change_flags_sva
bind pin_change_flags pin_change_flags_sva chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pin_change_summary_flag_o(pin_change_summary_flag_o),
  .pin_change_request_o(pin_change_request_o), .wake_request_o(wake_request_o));
`default_nettype wire

//--- verification/pin_partner.sv
// Far-side model: external levels on the port pins.
// Assumes the bench calls set_port to change one port at a time.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic clock_i,
  output var logic [7:0] pa_o = 8'h00,
  output var logic [7:0] pb_o = 8'h00,
  output var logic [7:0] pc_o = 8'h00,
  output var logic pe_o = 1'b0
);
  task set_port(input int p, input logic [7:0] v);
    begin
      @(posedge clock_i);
      if (p == 0) pa_o <= v;
      else if (p == 1) pb_o <= v;
      else if (p == 2) pc_o <= v;
      else pe_o <= v[3];
      repeat (8) @(posedge clock_i);
    end
  endtask
endmodule // pin_partner
`default_nettype wire

//--- verification/pin_change_flags_test.sv
// Self-checking bench for the pin change flag block.
// Assumes the pin model drives the ports and registers sit at four times their index.
`timescale 1ns/1ps
`default_nettype none
module pin_change_flags_test;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ext_en = 1'b0;
  logic lv_prog_en = 1'b0;
  logic [13:0] awaddr = 14'h0;
  logic [13:0] araddr = 14'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire [7:0] pa, pb, pc;
  wire pe, awready, wready, bvalid, arready, rvalid, summary, request, wake, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rv;
  logic [1:0] rr;
  always #10 clock_i = ~clock_i;
  pin_partner pins_u (.clock_i(clock_i), .pa_o(pa), .pb_o(pb), .pc_o(pc), .pe_o(pe));
  pin_change_flags dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .port_a_pin_i(pa),
    .port_b_pin_i(pb), .port_c_pin_i(pc), .port_e_bit3_pin_i(pe),
    .external_reset_pin_enable_i(ext_en), .low_voltage_programming_enable_i(lv_prog_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_change_summary_flag_o(summary), .pin_change_request_o(request),
    .wake_request_o(wake), .irq_o(irq));
  task results;
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task hang(input int n);
    if (n >= 50) begin
      err_total++;
      results;
    end
  endtask
  // One bus transfer; the answer lands in rv and rr.
  task bus(input bit w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    begin
      @(posedge clock_i);
      awaddr <= {idx, 2'b00};
      araddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      n = 0;
      @(negedge clock_i);
      while ((w ? awready : arready) !== 1'b1 && n < 50) begin
        n++;
        @(negedge clock_i);
      end
      hang(n);
      @(posedge clock_i);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      arvalid <= 1'b0;
      n = 0;
      @(negedge clock_i);
      while ((w ? bvalid : rvalid) !== 1'b1 && n < 50) begin
        n++;
        @(negedge clock_i);
      end
      hang(n);
      rv = rdata;
      rr = w ? bresp : rresp;
      @(posedge clock_i);
      bready <= 1'b0;
      rready <= 1'b0;
    end
  endtask
  task rchk(input logic [11:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rv, {24'h0, exp});
    chk({30'h0, rr}, 32'h0);
  endtask
  task t_reset;
    logic [11:0] ofs [0:7];
    begin
      ofs = '{12'hf0b, 12'hf0c, 12'hf12, 12'hf13, 12'hf1a, 12'hf1b, 12'hf27, 12'hf28};
      foreach (ofs[i]) rchk(ofs[i], 8'h00);
      bus(1'b0, 12'h0ff, 8'h00);
      chk({30'h0, rr}, 32'h2);
      bus(1'b1, 12'hf28, 8'hff);
      rchk(12'hf28, 8'h08);
      bus(1'b1, 12'hf28, 8'h00);
    end
  endtask
  task t_ports;
    bus(1'b1, 12'hf14, 8'h01);
    bus(1'b1, 12'hf13, 8'h02);
    bus(1'b1, 12'hf1b, 8'h80);
    bus(1'b1, 12'hf1c, 8'h01);
    pins_u.set_port(1, 8'h03);
    pins_u.set_port(2, 8'h81);
    rchk(12'hf12, 8'h01);
    rchk(12'hf1a, 8'h01);
    pins_u.set_port(1, 8'h00);
    pins_u.set_port(2, 8'h00);
    rchk(12'hf12, 8'h03);
    rchk(12'hf1a, 8'h81);
    bus(1'b1, 12'hf12, 8'h02);
    rchk(12'hf12, 8'h02);
    bus(1'b1, 12'hf12, 8'h00);
    bus(1'b1, 12'hf1a, 8'h7f);
    rchk(12'hf1a, 8'h01);
    bus(1'b1, 12'hf1a, 8'h00);
    rchk(12'hf1a, 8'h00);
  endtask
  // The pin rises so that its flag sets on the very edge that takes a clearing write.
  task t_edge_wins;
    fork
      pins_u.set_port(1, 8'h01);
      begin
        repeat (3) @(posedge clock_i);
        bus(1'b1, 12'hf12, 8'h00);
      end
    join
    rchk(12'hf12, 8'h01);
    bus(1'b1, 12'hf12, 8'h00);
    pins_u.set_port(1, 8'h00);
    rchk(12'hf12, 8'h00);
  endtask
  task t_port_e;
    bus(1'b1, 12'hf29, 8'h08);
    ext_en <= 1'b1;
    pins_u.set_port(3, 8'h08);
    rchk(12'hf27, 8'h00);
    ext_en <= 1'b0;
    lv_prog_en <= 1'b1;
    pins_u.set_port(3, 8'h00);
    pins_u.set_port(3, 8'h08);
    rchk(12'hf27, 8'h00);
    lv_prog_en <= 1'b0;
    pins_u.set_port(3, 8'h00);
    rchk(12'hf27, 8'h00);
    pins_u.set_port(3, 8'h08);
    rchk(12'hf27, 8'h08);
    bus(1'b1, 12'hf27, 8'h00);
    bus(1'b1, 12'hf28, 8'h08);
    pins_u.set_port(3, 8'h00);
    rchk(12'hf27, 8'h08);
    bus(1'b1, 12'hf27, 8'h00);
  endtask
  task t_a_irq;
    bus(1'b1, 12'hf41, 8'h01);
    bus(1'b1, 12'hf0c, 8'h10);
    bus(1'b1, 12'hf42, 8'h01);
    pins_u.set_port(0, 8'h10);
    rchk(12'hf0a, 8'h10);
    bus(1'b1, 12'hf0b, 8'h20);
    pins_u.set_port(0, 8'h30);
    pins_u.set_port(0, 8'h10);
    rchk(12'hf0a, 8'h30);
    @(negedge clock_i);
    chk({summary, request, irq}, 32'h5);
    bus(1'b1, 12'hf40, 8'h01);
    @(negedge clock_i);
    chk({request, wake}, 32'h3);
    bus(1'b1, 12'hf42, 8'h00);
    @(negedge clock_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 12'hf41, 8'h01);
    rchk(12'hf41, 8'h00);
    bus(1'b1, 12'hf0a, 8'h00);
    bus(1'b1, 12'hf40, 8'h00);
    @(negedge clock_i);
    chk({summary, request}, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset;
    t_ports;
    t_edge_wins;
    t_port_e;
    t_a_irq;
    results;
  end
endmodule // pin_change_flags_test
`default_nettype wire
